/* cao_core.sv */
/*
 * Execution slice of a small 8-bit core: pointer add, accumulator and
 * file register add/AND, add with carry, arithmetic shift and bit clear,
 * reached as an AHB-Lite slave.
 * Assumes one master with hready looped back, single word transfers.
 */
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
// What this block does
// RULE1: pointer add sign-extends a six-bit literal into the chosen pointer
// RULE2: pointer sum wraps modulo 65536 in both directions
// RULE3: one index bit picks pointer pair; no status flag changes
// RULE4: AND literal into accumulator; only zero flag updated
// RULE5: add literal to accumulator; carry, digit carry, zero updated
// RULE6: AND accumulator with addressed file register; only zero flag changes
// RULE7: destination bit 0 writes accumulator, 1 writes file register
// RULE8: add accumulator and file register; carry, digit carry, zero
// RULE9: shift file right; bit 0 to carry, bits 7..1 to 6..0
// RULE10: shift keeps sign bit; only carry and zero updated
// RULE11: add accumulator, file register and carry; all three flags updated
// RULE12: clear one chosen bit of file register; flags untouched
// RULE13: pointer add decoded from its opcode and done in one cycle
// RULE14: zero flag from 8-bit result; digit carry is carry out of bit 3
`timescale 1ns/1ps
`default_nettype none
module cao_core
	import cao_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata
);

	typedef enum logic [1:0] {
		B_IDLE = 2'b00,
		B_RD = 2'b01,
		B_EX = 2'b10
	} cao_bst_t;

	cao_bst_t st_q, st_d;
	logic dp_valid_q;
	logic dp_write_q;
	logic [9:0] dp_addr_q;
	logic [7:0] acc_q;
	cao_flags_t flags_q;
	logic [15:0] ptr_q [2];
	logic [OPC_W-1:0] instr_q;
	cao_op_t op_q;
	logic [31:0] hrdata_q;
	logic rd_mem_q;

	logic take;
	logic d1;
	logic dp_file;
	logic wr_any;
	logic wr_instr;
	logic wr_acc;
	logic wr_status;
	cao_op_t new_op;
	logic go_file;
	logic lit_exec;
	logic ptr_exec;
	logic ex_now;
	logic ex_dest_file;
	logic to_acc;
	logic to_file;
	logic flag_exec;
	cao_op_t alu_op;
	logic [OPC_W-1:0] alu_word;
	cao_alu_out_t alu_out;
	logic [FADDR_W-1:0] mem_addr;
	logic mem_re;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [7:0] mem_rdata;
	logic [15:0] k_sext;
	logic [31:0] reg_rd;
	logic rd_phase;
	logic wr_phase;
	logic st_rd;
	logic hit_instr;
	logic hit_acc;
	logic hit_status;
	logic [OPC_W-1:0] new_word;
	logic [FADDR_W-1:0] bus_fidx;
	logic [FADDR_W-1:0] word_fidx;
	logic [FADDR_W-1:0] ex_fidx;

	// one register slot of the map; shared by register writes and pointer writes
	function automatic logic at_ofs(input logic [9:0] a,
		input logic [9:0] ofs);
		return a == ofs;
	endfunction

	// hsize and htrans[0] carry nothing here: only single full words occur
	assign take = hsel && hready && htrans[1];
	assign d1 = (st_q == B_IDLE) && dp_valid_q;
	assign st_rd = (st_q == B_RD);
	assign rd_phase = d1 && !dp_write_q;
	assign wr_phase = d1 && dp_write_q;
	assign dp_file = dp_addr_q[FILE_SEL_BIT];
	assign hit_instr = at_ofs(dp_addr_q, OFS_INSTR);
	assign hit_acc = at_ofs(dp_addr_q, OFS_ACC);
	assign hit_status = at_ofs(dp_addr_q, OFS_STATUS);
	assign wr_any = wr_phase && !dp_file;
	assign wr_instr = wr_any && hit_instr;
	assign wr_acc = wr_any && hit_acc;
	assign wr_status = wr_any && hit_status;
	// instruction word is decoded straight off the write data phase
	assign new_word = hwdata[OPC_W-1:0];
	assign new_op = cao_decode(new_word); // RULE13
	assign go_file = wr_instr && cao_uses_file(new_op);
	assign lit_exec = wr_instr && ((new_op == OP_ANDL) || (new_op == OP_ADDL));
	assign ptr_exec = wr_instr && (new_op == OP_ADDPTR); // RULE13
	assign ex_now = (st_q == B_EX);
	assign ex_dest_file = (op_q == OP_BCLR) || instr_q[F_DEST];
	// literal results land at once, file results one cycle later
	assign to_acc = lit_exec || (ex_now && !ex_dest_file); // RULE7
	assign to_file = ex_now && ex_dest_file; // RULE7 RULE12
	assign flag_exec = lit_exec || ex_now;

	// reads and file instructions take one extra data-phase cycle
	assign hreadyout = !(rd_phase || go_file);
	assign hresp = 1'b0;
	assign hrdata = rd_mem_q ? {24'h000000, mem_rdata} : hrdata_q;

	assign alu_op = ex_now ? op_q : new_op;
	assign alu_word = ex_now ? instr_q : new_word;
	assign k_sext = {{10{new_word[F_K6_HI]}}, new_word[F_K6_HI:0]}; // RULE1

	// executing word wins the port; bus file access never overlaps it
	assign ex_fidx = instr_q[FADDR_W-1:0];
	assign word_fidx = new_word[FADDR_W-1:0];
	assign bus_fidx = dp_addr_q[FILE_IDX_HI:FILE_IDX_LO];
	assign mem_addr = ex_now ? ex_fidx :
		(wr_instr ? word_fidx : bus_fidx); // RULE6
	assign mem_re = (rd_phase && dp_file) || go_file;
	assign mem_we = (wr_phase && dp_file) || to_file;
	assign mem_wdata = to_file ? alu_out.res : hwdata[7:0];

	// unmapped slots read as zero
	always_comb begin
		case (dp_addr_q)
		OFS_INSTR: reg_rd = {18'h00000, instr_q};
		OFS_ACC: reg_rd = {24'h000000, acc_q};
		OFS_STATUS: reg_rd = {29'h00000000, flags_q};
		OFS_PTR0: reg_rd = {16'h0000, ptr_q[0]};
		OFS_PTR1: reg_rd = {16'h0000, ptr_q[1]};
		default: reg_rd = 32'h00000000;
		endcase
	end

	always_comb begin
		case (st_q)
		B_IDLE: begin
			if (rd_phase)
				st_d = B_RD;
			else if (go_file)
				st_d = B_EX;
			else
				st_d = B_IDLE;
		end
		B_RD: st_d = B_IDLE;
		B_EX: st_d = B_IDLE;
		default: st_d = B_IDLE;
		endcase
	end

	// literal ops run in the write cycle, file ops in the execute cycle
	cao_alu u_alu (
		.op(alu_op),
		.word(alu_word),
		.acc(acc_q),
		.fval(mem_rdata),
		.carry_in(flags_q.c),
		.out(alu_out)
	);

	cao_mem #(
		.W(8),
		.DEPTH(FILE_DEPTH),
		.AW(FADDR_W)
	) u_mem (
		.clk(hclk),
		.rst_n(hresetn),
		.addr(mem_addr),
		.re(mem_re),
		.we(mem_we),
		.wdata(mem_wdata),
		.rdata_q(mem_rdata)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			st_q <= B_IDLE;
		else
			st_q <= st_d;
	end

	// address phase is captured only when the previous data phase ends
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid_q <= 1'b0;
			dp_write_q <= 1'b0;
			dp_addr_q <= 10'h000;
		end else if (hready) begin
			dp_valid_q <= take;
			dp_write_q <= hwrite;
			dp_addr_q <= haddr[9:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata_q <= 32'h00000000;
		else if (rd_phase)
			hrdata_q <= reg_rd;
	end

	// memory data arrive a cycle late, so their select is held through it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rd_mem_q <= 1'b0;
		else if (rd_phase)
			rd_mem_q <= dp_file;
		else if (!st_rd)
			rd_mem_q <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			instr_q <= INSTR_RST;
		else if (wr_instr)
			instr_q <= new_word;
	end

	// decode kept beside the word so the execute cycle needs no decoder
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			op_q <= OP_NONE;
		else if (wr_instr)
			op_q <= new_op;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			acc_q <= ACC_RST;
		else if (wr_acc)
			acc_q <= hwdata[7:0];
		else if (to_acc)
			acc_q <= alu_out.res; // RULE4 RULE5 RULE7
	end

	// pointer add never reaches here, so it leaves the flags alone
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= FLAGS_RST;
		end else if (wr_status) begin
			flags_q <= hwdata[ST_Z:ST_C];
		end else if (flag_exec) begin
			if (alu_out.upd.c)
				flags_q.c <= alu_out.fl.c; // RULE9 RULE11
			if (alu_out.upd.dc)
				flags_q.dc <= alu_out.fl.dc; // RULE14
			if (alu_out.upd.z)
				flags_q.z <= alu_out.fl.z; // RULE10 RULE14
		end
	end

	// each pointer pair is written by the bus or by its own add
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_ptr
			logic sel_bus;
			logic sel_add;
			logic [15:0] sum;
			assign sel_bus = wr_any &&
				at_ofs(dp_addr_q, (gi == 0) ? OFS_PTR0 : OFS_PTR1);
			assign sel_add = ptr_exec &&
				(new_word[F_PIDX] == 1'(gi)); // RULE3
			// carry out of bit 15 is dropped on purpose: pointers wrap
			assign sum = ptr_q[gi] + k_sext; // RULE2
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn)
					ptr_q[gi] <= PTR_RST;
				else if (sel_bus)
					ptr_q[gi] <= hwdata[15:0];
				else if (sel_add)
					ptr_q[gi] <= sum; // RULE1 RULE13
			end
		end
	endgenerate

endmodule
`default_nettype wire

/* cao_pkg.sv */
/*
 * Shared constants, opcode patterns, register map and carrier types for
 * the add/logic execution slice. Assumes a 32-bit AHB-Lite register bus
 * and 14-bit instruction words delivered through the instruction register.
 */
`default_nettype none
package cao_pkg;

	localparam int OPC_W = 14;
	localparam int FADDR_W = 7;
	localparam int FILE_DEPTH = 128;

	// register map, byte addresses within the slave window
	localparam logic [9:0] OFS_INSTR = 10'h000;
	localparam logic [9:0] OFS_ACC = 10'h004;
	localparam logic [9:0] OFS_STATUS = 10'h008;
	localparam logic [9:0] OFS_PTR0 = 10'h00c;
	localparam logic [9:0] OFS_PTR1 = 10'h010;
	localparam int FILE_SEL_BIT = 9;
	localparam int FILE_IDX_LO = 2;
	localparam int FILE_IDX_HI = 8;

	// status register bit positions
	localparam int ST_C = 0;
	localparam int ST_DC = 1;
	localparam int ST_Z = 2;

	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [13:0] INSTR_RST = 14'h0000;

	// opcode patterns, compared against the upper bits of the word
	localparam logic [6:0] PAT_ADDPTR = 7'h62;
	localparam logic [5:0] PAT_ANDL = 6'h39;
	localparam logic [5:0] PAT_ADDL = 6'h3e;
	localparam logic [5:0] PAT_ANDF = 6'h05;
	localparam logic [5:0] PAT_ADDF = 6'h07;
	localparam logic [5:0] PAT_ARITH_SHIFT_RIGHT_FILE = 6'h37;
	localparam logic [5:0] PAT_ADDC = 6'h3d;
	localparam logic [3:0] PAT_BCLR = 4'h4;

	// instruction field positions
	localparam int F_DEST = 7;
	localparam int F_PIDX = 6;
	localparam int F_K6_HI = 5;
	localparam int F_BIT_LO = 7;
	localparam int F_BIT_HI = 9;

	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_ADDPTR = 4'h1,
		OP_ANDL = 4'h2,
		OP_ADDL = 4'h3,
		OP_ANDF = 4'h4,
		OP_ADDF = 4'h5,
		OP_ARITH_SHIFT_RIGHT_FILE = 4'h6,
		OP_ADDC = 4'h7,
		OP_BCLR = 4'h8
	} cao_op_t;

	typedef struct packed {
		logic z;
		logic dc;
		logic c;
	} cao_flags_t;

	typedef struct packed {
		logic [7:0] res;
		cao_flags_t fl;
		cao_flags_t upd;
	} cao_alu_out_t;

	localparam cao_flags_t FLAGS_RST = 3'h0;

	function automatic cao_op_t cao_decode(input logic [OPC_W-1:0] w);
		cao_op_t op;
		op = OP_NONE;
		if (w[13:7] == PAT_ADDPTR)
			op = OP_ADDPTR;
		else if (w[13:8] == PAT_ANDL)
			op = OP_ANDL;
		else if (w[13:8] == PAT_ADDL)
			op = OP_ADDL;
		else if (w[13:8] == PAT_ANDF)
			op = OP_ANDF;
		else if (w[13:8] == PAT_ADDF)
			op = OP_ADDF;
		else if (w[13:8] == PAT_ARITH_SHIFT_RIGHT_FILE)
			op = OP_ARITH_SHIFT_RIGHT_FILE;
		else if (w[13:8] == PAT_ADDC)
			op = OP_ADDC;
		else if (w[13:10] == PAT_BCLR)
			op = OP_BCLR;
		return op;
	endfunction

	function automatic logic cao_uses_file(input cao_op_t op);
		return (op == OP_ANDF) || (op == OP_ADDF) || (op == OP_ARITH_SHIFT_RIGHT_FILE) ||
			(op == OP_ADDC) || (op == OP_BCLR);
	endfunction

endpackage
`default_nettype wire

/* cao_mem.sv */
/*
 * Small single-port file register memory with registered read data.
 * Assumes the caller never reads and writes in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module cao_mem #(
	parameter int W = 8,
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [AW-1:0] addr,
	input wire logic re,
	input wire logic we,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] rdata_q
);

	logic [W-1:0] mem [DEPTH];

	// array has no reset: contents are undefined until software writes
	always_ff @(posedge clk) begin
		if (we)
			mem[addr] <= wdata;
	end

	// read data holds between reads so a stalled consumer still sees it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			rdata_q <= '0;
		else if (re)
			rdata_q <= mem[addr];
	end

endmodule
`default_nettype wire

/* cao_alu.sv */
/*
 * Combinational 8-bit arithmetic/logic unit for the accumulator and file
 * operations. Assumes operands are stable for the whole cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module cao_alu
	import cao_pkg::*;
(
	input var cao_op_t op,
	input wire logic [OPC_W-1:0] word,
	input wire logic [7:0] acc,
	input wire logic [7:0] fval,
	input wire logic carry_in,
	output cao_alu_out_t out
);

	logic is_lit;
	logic [7:0] opb;
	logic cin;
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [2:0] bpos;
	logic [7:0] bclr;

	assign is_lit = (op == OP_ANDL) || (op == OP_ADDL);
	assign opb = is_lit ? word[7:0] : fval;
	assign cin = (op == OP_ADDC) ? carry_in : 1'b0; // RULE11
	assign sum9 = {1'b0, acc} + {1'b0, opb} + {8'h00, cin};
	assign sum5 = {1'b0, acc[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin}; // RULE14
	assign bpos = word[F_BIT_HI:F_BIT_LO];
	assign bclr = fval & ~(8'h01 << bpos); // RULE12

	always_comb begin
		out = '0;
		case (op)
		OP_ANDL, OP_ANDF: begin
			out.res = acc & opb; // RULE4 RULE6
			out.upd.z = 1'b1;
		end
		OP_ADDL, OP_ADDF, OP_ADDC: begin
			out.res = sum9[7:0]; // RULE5 RULE8 RULE11
			out.fl.c = sum9[8];
			out.fl.dc = sum5[4]; // RULE14
			out.upd = 3'h7;
		end
		OP_ARITH_SHIFT_RIGHT_FILE: begin
			out.res = {fval[7], fval[7:1]}; // RULE9 RULE10
			out.fl.c = fval[0]; // RULE9
			out.upd.c = 1'b1; // RULE10
			out.upd.z = 1'b1;
		end
		OP_BCLR: begin
			out.res = bclr; // RULE12
		end
		default: begin
			out = '0;
		end
		endcase
		out.fl.z = (out.res == 8'h00); // RULE14
	end

endmodule
`default_nettype wire

/* cao_core_assertions.sv */
/*
 * Port checker for cao_core bus timing and read widths.
 * Assumes one master with hready looped back from hreadyout.
 */
`timescale 1ns/1ps
`default_nettype none
module cao_core_assertions
	import cao_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata
);
	wire logic tk = hsel & hready & htrans[1];
	wire logic rd_t = tk & !hwrite;
	wire logic wr_t = tk & hwrite;
	wire logic [9:0] a = haddr[9:0];
	wire logic [5:0] op = hwdata[13:8];
	wire logic fop = op == PAT_ANDF || op == PAT_ADDF || op == PAT_ARITH_SHIFT_RIGHT_FILE ||
		op == PAT_ADDC || hwdata[13:10] == PAT_BCLR;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_read_wait: assert property (rd_t |=> !hreadyout ##1 hreadyout)
		else $error("read wait count wrong");
	a_reg_write: assert property (wr_t && a != OFS_INSTR |=> hreadyout)
		else $error("register write stalled");
	a_ptr_add_one:
		assert property (wr_t && a == OFS_INSTR ##1 hwdata[13:7] == PAT_ADDPTR
		|-> hreadyout) else $error("pointer add not single cycle");
	a_file_op_wait:
		assert property (wr_t && a == OFS_INSTR ##1 fop
		|-> !hreadyout ##1 hreadyout) else $error("file op wait wrong");
	a_gap_zero: assert property (rd_t && !a[9] && a > OFS_PTR1
		|=> ##1 hrdata == 32'h0) else $error("unmapped read not zero");
	a_acc_width:
		assert property (rd_t && a == OFS_ACC |=> ##1 hrdata[31:8] == 24'h0)
		else $error("accumulator upper bits set");
	a_flag_width:
		assert property (rd_t && a == OFS_STATUS |=> ##1 hrdata[31:3] == 29'h0)
		else $error("status upper bits set");
	a_ptr_width:
		assert property (rd_t && (a == OFS_PTR0 || a == OFS_PTR1)
		|=> ##1 hrdata[31:16] == 16'h0) else $error("pointer upper bits set");
	a_file_width:
		assert property (rd_t && a[9] |=> ##1 hrdata[31:8] == 24'h0)
		else $error("file upper bits set");
endmodule
`default_nettype wire

/* cao_core_bench.sv */
/*
 * Self-checking bench for cao_core: bus tasks and a reference mirror.
 * Assumes hready looped back from hreadyout, single slave.
 */
`timescale 1ns/1ps
`default_nettype none
module cao_core_bench import cao_pkg::*;;
	logic hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata;
	logic [1:0] htrans;
	wire logic hready, hreadyout, hresp;
	wire logic [31:0] hrdata;
	int errors, tests_run;
	logic [7:0] acc;
	logic [7:0] fm [0:127];
	logic [15:0] ptr [0:1];
	logic c, dc, z;
	logic [13:0] last;
	logic [31:0] v;
	int fidx [3] = '{0, 5, 127};
	logic [7:0] finit [3] = '{8'hc4, 8'h81, 8'h7f};
	logic [13:0] prog [17] = '{14'h3ef1, 14'h311f, 14'h3160, 14'h313f,
		14'h3e38, 14'h3ef1, 14'h39f0, 14'h3900, 14'h077f, 14'h0785,
		14'h0500, 14'h0580, 14'h3785, 14'h3700, 14'h3d7f, 14'h3dff,
		14'h1380};
	assign hready = hreadyout;
	cao_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata));
	initial begin
		hclk = 1'h0;
		forever #4 hclk = ~hclk;
	end
	task automatic stop_test();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// bounded so a stuck slave ends the run instead of hanging it
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'h1 && n < 40);
		if (hready !== 1'h1) begin
			errors++;
			stop_test();
		end
	endtask
	task automatic bus(input logic [31:0] a, input logic w,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	function automatic logic [31:0] faddr(input int i);
		return 32'h200 + 32'(i) * 32'h4;
	endfunction
	task automatic add8(input logic [7:0] a, b, input logic ci,
		output logic [7:0] r);
		logic [8:0] s;
		logic [4:0] h;
		s = {1'h0, a} + {1'h0, b} + {8'h0, ci};
		h = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, ci};
		r = s[7:0];
		c = s[8];
		dc = h[4];
	endtask
	task automatic model(input logic [13:0] w);
		logic [7:0] f, r;
		logic u, lit;
		int a;
		a = int'(w[6:0]);
		f = fm[a];
		u = 1'h1;
		lit = w[13:8] == PAT_ANDL || w[13:8] == PAT_ADDL;
		if (w[13:7] == PAT_ADDPTR) begin
			ptr[w[6]] = ptr[w[6]] + {{10{w[5]}}, w[5:0]};
			u = 1'h0;
		end else if (w[13:10] == PAT_BCLR) begin
			fm[a][w[9:7]] = 1'h0;
			u = 1'h0;
		end else begin
			case (w[13:8])
			PAT_ANDL: r = acc & w[7:0];
			PAT_ADDL: add8(acc, w[7:0], 1'h0, r);
			PAT_ANDF: r = acc & f;
			PAT_ADDF: add8(acc, f, 1'h0, r);
			PAT_ARITH_SHIFT_RIGHT_FILE: begin
				c = f[0];
				r = {f[7], f[7:1]};
			end
			PAT_ADDC: add8(acc, f, c, r);
			default: u = 1'h0;
			endcase
		end
		if (u) begin
			z = r == 8'h00;
			if (w[7] && !lit)
				fm[a] = r;
			else
				acc = r;
		end
		last = w;
	endtask
	task automatic chk_all();
		bus({22'h0, OFS_ACC}, 1'h0, 32'h0, v);
		check("acc", {24'h0, acc}, v);
		bus({22'h0, OFS_STATUS}, 1'h0, 32'h0, v);
		check("status", {29'h0, z, dc, c}, v);
		bus({22'h0, OFS_PTR0}, 1'h0, 32'h0, v);
		check("ptr0", {16'h0, ptr[0]}, v);
		bus({22'h0, OFS_PTR1}, 1'h0, 32'h0, v);
		check("ptr1", {16'h0, ptr[1]}, v);
		bus({22'h0, OFS_INSTR}, 1'h0, 32'h0, v);
		check("instr", {18'h0, last}, v);
		foreach (fidx[i]) begin
			bus(faddr(fidx[i]), 1'h0, 32'h0, v);
			check("file", {24'h0, fm[fidx[i]]}, v);
		end
	endtask
	task automatic exec(input logic [13:0] w);
		bus({22'h0, OFS_INSTR}, 1'h1, {18'h0, w}, v);
		model(w);
		chk_all();
	endtask
	initial begin
		hresetn = 1'h0;
		hsel = 1'h1;
		htrans = 2'h0;
		hwrite = 1'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		errors = 0;
		tests_run = 0;
		acc = ACC_RST;
		ptr[0] = PTR_RST;
		ptr[1] = PTR_RST;
		{z, dc, c} = FLAGS_RST;
		last = INSTR_RST;
		repeat (10) @(posedge hclk);
		hresetn <= 1'h1;
		foreach (fidx[i]) begin
			fm[fidx[i]] = finit[i];
			bus(faddr(fidx[i]), 1'h1, {24'h0, finit[i]}, v);
		end
		chk_all();
		acc = 8'h0f;
		ptr[0] = 16'hfffe;
		ptr[1] = 16'h0005;
		bus({22'h0, OFS_ACC}, 1'h1, {24'h0, acc}, v);
		bus({22'h0, OFS_PTR0}, 1'h1, {16'h0, ptr[0]}, v);
		bus({22'h0, OFS_PTR1}, 1'h1, {16'h0, ptr[1]}, v);
		bus(32'h100, 1'h1, 32'hffffffff, v);
		bus(32'h100, 1'h0, 32'h0, v);
		check("gap", 32'h0, v);
		foreach (prog[i]) exec(prog[i]);
		exec(14'h1005);
		exec(14'h0000);
		stop_test();
	end
endmodule
bind cao_core cao_core_assertions chk (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
`default_nettype wire
